// [inc/fiap_pkg.sv]
// package: constants, register map and types of the flash mailbox controller
package fiap_pkg;

   // ==========================================
   // register map (byte addresses on the apb)
   localparam logic [11:0] OFF_STATUS  = 12'h000;
   localparam logic [11:0] OFF_COMMAND = 12'h004;
   localparam logic [11:0] OFF_ADDR_LO = 12'h008;
   localparam logic [11:0] OFF_ADDR_HI = 12'h00c;
   localparam logic [11:0] OFF_DATA    = 12'h010;
   localparam logic [11:0] OFF_CONFIG  = 12'h014;

   // ==========================================
   // field positions and reset values
   localparam int          STAT_REFUSED_BIT = 0;
   localparam int          STAT_BUSY_BIT    = 2;
   localparam int          CMD_IRQ_BIT      = 7;
   localparam int          CFG_IAP_EN_BIT   = 6;
   localparam int          ADDR_HI_BLK_BIT  = 7;
   localparam logic [7:0]  CFG_WR_MASK      = 8'h43;
   localparam logic [7:0]  RST_BYTE         = 8'h00;

   // ==========================================
   // commands, keys and signature addresses
   localparam logic [6:0]  CMD_CHIP_ERASE   = 7'h01;
   localparam logic [6:0]  CMD_SIGNATURE    = 7'h0a;
   localparam logic [6:0]  CMD_SECTOR_ERASE = 7'h0b;
   localparam logic [6:0]  CMD_VERIFY       = 7'h0c;
   localparam logic [6:0]  CMD_BLOCK_ERASE  = 7'h0d;
   localparam logic [6:0]  CMD_PROGRAM      = 7'h0e;
   localparam logic [7:0]  ERASE_KEY        = 8'h55;
   localparam logic [7:0]  SIG_MFR_ADDR     = 8'h30;
   localparam logic [7:0]  SIG_DEV_ADDR     = 8'h31;
   localparam logic [7:0]  SIG_NONE         = 8'hff;

   // ==========================================
   // address window of the overlay and operation lengths in oscillator ticks
   localparam logic [15:0] LOW_WINDOW_TOP   = 16'h2000;
   localparam logic [15:0] TICKS_PROGRAM    = 16'h0014;
   localparam logic [15:0] TICKS_SECTOR     = 16'h0190;
   localparam logic [15:0] TICKS_BLOCK      = 16'h0320;
   localparam logic [15:0] TICKS_CHIP       = 16'h03e8;

   // ==========================================
   // types
   typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_EXTERNAL} fiap_src_t;
   typedef enum logic [2:0] {OP_NONE, OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP,
                             OP_READ} fiap_op_t;
   typedef struct packed {
      logic        req;
      fiap_op_t    op;
      logic        blk;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fiap_flash_t;

endpackage

// [src/fiap_bank_map.sv]
// bank map: overlay decision, visibility of the issuing code and target block
`timescale 1ns/1ps
`default_nettype none
module fiap_bank_map (
   input  wire logic               external_access_pin_n,
   input  wire logic [1:0]         bank_sel,
   input  wire fiap_pkg::fiap_src_t issue_src,
   input  wire logic [15:0]        issue_pc,
   input  wire logic [15:0]        target_addr,
   output logic                    overlay,
   output logic                    src_visible,
   output logic                    target_blk
);
   logic pc_low;
   logic tgt_low;

   // secondary block sits over the low window of the primary block
   assign overlay = external_access_pin_n && (bank_sel != 2'b00);
   assign pc_low  = issue_pc < fiap_pkg::LOW_WINDOW_TOP;
   assign tgt_low = target_addr < fiap_pkg::LOW_WINDOW_TOP;

   // code hidden by the overlay cannot issue an operation
   always_comb begin
      src_visible = 1'b1;
      target_blk  = 1'b0;
      unique case (issue_src)
         fiap_pkg::SRC_PRIMARY: begin
            src_visible = !(overlay && pc_low);
            target_blk  = 1'b1;
         end
         fiap_pkg::SRC_SECONDARY: begin
            src_visible = overlay && pc_low;
            target_blk  = 1'b0;
         end
         fiap_pkg::SRC_EXTERNAL: begin
            target_blk  = (target_addr[15:13] == 3'b111) || (overlay && tgt_low);
         end
         default: begin
            src_visible = 1'b0;
         end
      endcase
   end
endmodule // fiap_bank_map
`default_nettype wire

// [src/fiap_op_timer.sv]
// operation timer: runs the timing oscillator and counts its ticks
`timescale 1ns/1ps
`default_nettype none
module fiap_op_timer (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic [15:0] len,
   input  wire logic        osc_tick,
   output logic             osc_en,
   output logic             done
);
   logic [15:0] cnt;
   logic [15:0] lim;
   logic [15:0] next_cnt;
   logic [15:0] next_lim;
   logic        next_osc_en;
   logic        next_done;

   // oscillator on only while an operation is timed
   always_comb begin
      next_cnt    = cnt;
      next_lim    = lim;
      next_osc_en = osc_en;
      next_done   = 1'b0;
      if (start) begin
         next_cnt    = 16'h0000;
         next_lim    = len;
         next_osc_en = 1'b1;
      end else if (osc_en && osc_tick) begin
         next_cnt = cnt + 16'h0001;
         if (cnt + 16'h0001 >= lim) begin
            next_osc_en = 1'b0;
            next_done   = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt    <= 16'h0000;
         lim    <= 16'h0000;
         osc_en <= 1'b0;
         done   <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         lim    <= next_lim;
         osc_en <= next_osc_en;
         done   <= next_done;
      end
   end
endmodule // fiap_op_timer
`default_nettype wire

// [src/fiap_mailbox.sv]
// mailbox controller: apb registers, command decode and flash sequencing
//
// What this block does
// - signature command returns maker and device bytes
// - cpu runs from one block, other busy
// - cpu runs external code during reprogramming
// - six mailbox registers start and observe operations
// - core and controller share external clock
// - timing oscillator runs only during operations
// - program addresses are sixteen bits wide
// - pin and bank bits decide overlay
// - hidden block code cannot issue programming
// - hidden block programmable from other block
// - code never modifies its own block, except by chip erase
// - primary-block code targets secondary block
// - secondary-block code targets primary block
// - external code: target from address, banking
// - commands ignored until enable bit set
// - command register write starts the operation
// - status bit two shows operation pending
// - command bit seven raises internal interrupt
// - locked target blocks refuse programming commands
`timescale 1ns/1ps
`default_nettype none
module fiap_mailbox #(
   parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
   parameter logic [7:0] DEV_ID = 8'h3c  // arbitrary value
) (
   input  wire logic                core_clk,
   input  wire logic                nrst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                external_access_pin_n,
   input  wire fiap_pkg::fiap_src_t issue_src,
   input  wire logic [15:0]         issue_pc,
   input  wire logic [1:0]          lock_blk,
   input  wire logic                osc_tick,
   input  wire logic [7:0]          flash_rdata,
   output fiap_pkg::fiap_flash_t    flash_cmd,
   output logic                     osc_en,
   output logic [1:0]               blk_busy,
   output logic                     overlay_active,
   output logic                     ext_irq_one,
   output logic                     ext_irq_one_internal
);
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_READ} fiap_state_t;

   // ==========================================
   // state
   fiap_state_t           st;
   fiap_state_t           next_st;
   logic [7:0]            cmd;
   logic [7:0]            next_cmd;
   logic [7:0]            addr_lo;
   logic [7:0]            next_addr_lo;
   logic [7:0]            addr_hi;
   logic [7:0]            next_addr_hi;
   logic [7:0]            data;
   logic [7:0]            next_data;
   logic [7:0]            cfg;
   logic [7:0]            next_cfg;
   logic                  refused;
   logic                  next_refused;
   logic [31:0]           next_prdata;
   logic                  next_pready;
   logic                  next_pslverr;
   fiap_pkg::fiap_flash_t next_flash;
   logic [1:0]            next_blk_busy;
   logic                  next_overlay;
   logic                  next_irq;
   logic                  next_irq_int;

   // ==========================================
   // decode wires
   logic                  acc;
   logic                  hit;
   logic                  wr;
   logic                  wr_cmd;
   logic                  iap_en;
   logic                  busy;
   logic                  accept;
   logic [31:0]           rd_mux;
   logic [15:0]           tgt_addr;
   logic                  map_overlay;
   logic                  map_visible;
   logic                  map_tgt;
   fiap_pkg::fiap_op_t    dec_op;
   logic                  dec_blk;
   logic [15:0]           dec_len;
   logic                  dec_sig;
   logic                  dec_bad;
   logic                  refuse;
   logic                  tstart;
   logic                  tdone;

   // ==========================================
   // submodules
   fiap_bank_map u_map (
      .external_access_pin_n (external_access_pin_n),
      .bank_sel              (cfg[1:0]),
      .issue_src             (issue_src),
      .issue_pc              (issue_pc),
      .target_addr           (tgt_addr),
      .overlay               (map_overlay),
      .src_visible           (map_visible),
      .target_blk            (map_tgt)
   );

   fiap_op_timer u_timer (
      .core_clk (core_clk),
      .nrst     (nrst),
      .start    (tstart),
      .len      (dec_len),
      .osc_tick (osc_tick),
      .osc_en   (osc_en),
      .done     (tdone)
   );

   // ==========================================
   // apb decode: three-cycle access with one wait cycle, completes when pready is high
   assign acc      = psel && penable;
   assign wr       = acc && pready && pwrite && !pslverr;
   assign wr_cmd   = wr && (paddr == fiap_pkg::OFF_COMMAND);
   assign iap_en   = cfg[fiap_pkg::CFG_IAP_EN_BIT];
   assign busy     = (st != ST_IDLE);
   assign accept   = wr_cmd && !busy && iap_en;
   assign tgt_addr = {addr_hi, addr_lo};

   // address match and read mux of the six mailbox registers
   always_comb begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         fiap_pkg::OFF_STATUS: begin
            rd_mux[fiap_pkg::STAT_BUSY_BIT]    = busy;
            rd_mux[fiap_pkg::STAT_REFUSED_BIT] = refused;
         end
         fiap_pkg::OFF_COMMAND: rd_mux[7:0] = cmd;
         fiap_pkg::OFF_ADDR_LO: rd_mux[7:0] = addr_lo;
         fiap_pkg::OFF_ADDR_HI: rd_mux[7:0] = addr_hi;
         fiap_pkg::OFF_DATA:    rd_mux[7:0] = data;
         fiap_pkg::OFF_CONFIG:  rd_mux[7:0] = cfg;
         default:               hit         = 1'b0;
      endcase
   end

   // command decode against the written command byte
   always_comb begin
      dec_op  = fiap_pkg::OP_NONE;
      dec_blk = map_tgt;
      dec_len = 16'h0000;
      dec_sig = 1'b0;
      dec_bad = 1'b0;
      case (pwdata[6:0])
         fiap_pkg::CMD_PROGRAM: begin
            dec_op  = fiap_pkg::OP_PROGRAM;
            dec_len = fiap_pkg::TICKS_PROGRAM;
         end
         fiap_pkg::CMD_SECTOR_ERASE: begin
            dec_op  = fiap_pkg::OP_SECTOR;
            dec_len = fiap_pkg::TICKS_SECTOR;
         end
         fiap_pkg::CMD_BLOCK_ERASE: begin
            dec_op  = fiap_pkg::OP_BLOCK;
            dec_len = fiap_pkg::TICKS_BLOCK;
            dec_blk = addr_hi[fiap_pkg::ADDR_HI_BLK_BIT];
            dec_bad = (data != fiap_pkg::ERASE_KEY);
         end
         fiap_pkg::CMD_CHIP_ERASE: begin
            dec_op  = fiap_pkg::OP_CHIP;
            dec_len = fiap_pkg::TICKS_CHIP;
            dec_bad = external_access_pin_n || (data != fiap_pkg::ERASE_KEY);
         end
         fiap_pkg::CMD_VERIFY: dec_op  = fiap_pkg::OP_READ;
         fiap_pkg::CMD_SIGNATURE: dec_sig = 1'b1;
         default: dec_op = fiap_pkg::OP_NONE;
      endcase
   end

   // refusal: hidden source, own block, locked target
   always_comb begin
      refuse = 1'b0;
      if (dec_op != fiap_pkg::OP_NONE) begin
         if (!map_visible) begin
            refuse = 1'b1;
         end
         if (dec_op == fiap_pkg::OP_CHIP) begin
            refuse = refuse || (lock_blk != 2'b00);
         end else if (dec_op != fiap_pkg::OP_READ) begin
            refuse = refuse || lock_blk[dec_blk];
            if (issue_src != fiap_pkg::SRC_EXTERNAL) begin
               refuse = refuse ||
                        (dec_blk == (issue_src == fiap_pkg::SRC_SECONDARY));
            end
         end
         refuse = refuse || dec_bad;
      end
   end

   assign tstart = accept && !refuse && (dec_len != 16'h0000);

   // ==========================================
   // next state of registers, bus answer and sequencer
   always_comb begin
      next_st         = st;
      next_cmd        = cmd;
      next_addr_lo    = addr_lo;
      next_addr_hi    = addr_hi;
      next_data       = data;
      next_cfg        = cfg;
      next_refused    = refused;
      next_flash      = flash_cmd;
      next_flash.req  = 1'b0;
      next_blk_busy   = blk_busy;
      next_overlay    = map_overlay;
      next_irq        = tdone && cmd[fiap_pkg::CMD_IRQ_BIT];
      next_irq_int    = iap_en && cmd[fiap_pkg::CMD_IRQ_BIT];
      next_pready     = acc && !pready;
      next_pslverr    = acc && !pready && !hit;
      next_prdata     = (acc && !pready) ? rd_mux : prdata;
      // plain register writes
      if (wr && paddr == fiap_pkg::OFF_ADDR_LO) begin
         next_addr_lo = pwdata[7:0];
      end
      if (wr && paddr == fiap_pkg::OFF_ADDR_HI) begin
         next_addr_hi = pwdata[7:0];
      end
      if (wr && paddr == fiap_pkg::OFF_DATA) begin
         next_data = pwdata[7:0];
      end
      if (wr && paddr == fiap_pkg::OFF_CONFIG) begin
         next_cfg = pwdata[7:0] & fiap_pkg::CFG_WR_MASK;
      end
      // accepted command write
      if (accept) begin
         next_cmd     = pwdata[7:0];
         next_refused = refuse;
         if (dec_sig) begin
            if (addr_lo == fiap_pkg::SIG_MFR_ADDR) begin
               next_data = MFR_ID;
            end else if (addr_lo == fiap_pkg::SIG_DEV_ADDR) begin
               next_data = DEV_ID;
            end else begin
               next_data = fiap_pkg::SIG_NONE;
            end
         end else if (!refuse && dec_op != fiap_pkg::OP_NONE) begin
            next_flash.req   = 1'b1;
            next_flash.op    = dec_op;
            next_flash.blk   = dec_blk;
            next_flash.addr  = tgt_addr;
            next_flash.wdata = data;
            if (dec_op == fiap_pkg::OP_READ) begin
               next_st = ST_READ;
            end else begin
               next_st = ST_RUN;
               // only the target block stalls and the other keeps fetching, except chip erase, which stalls both
               if (dec_op == fiap_pkg::OP_CHIP) begin
                  next_blk_busy = 2'b11;
               end else begin
                  next_blk_busy = dec_blk ? 2'b10 : 2'b01;
               end
            end
         end
      end
      // sequencer progress
      unique case (st)
         ST_IDLE: begin
         end
         ST_READ: begin
            next_data = flash_rdata;
            next_st   = ST_IDLE;
         end
         ST_RUN: begin
            if (tdone) begin
               next_st       = ST_IDLE;
               next_blk_busy = 2'b00;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st                   <= ST_IDLE;
         cmd                  <= fiap_pkg::RST_BYTE;
         addr_lo              <= fiap_pkg::RST_BYTE;
         addr_hi              <= fiap_pkg::RST_BYTE;
         data                 <= fiap_pkg::RST_BYTE;
         cfg                  <= fiap_pkg::RST_BYTE;
         refused              <= 1'b0;
         prdata               <= 32'h0000_0000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
         flash_cmd            <= '0;
         blk_busy             <= 2'b00;
         overlay_active       <= 1'b0;
         ext_irq_one          <= 1'b0;
         ext_irq_one_internal <= 1'b0;
      end else begin
         st                   <= next_st;
         cmd                  <= next_cmd;
         addr_lo              <= next_addr_lo;
         addr_hi              <= next_addr_hi;
         data                 <= next_data;
         cfg                  <= next_cfg;
         refused              <= next_refused;
         prdata               <= next_prdata;
         pready               <= next_pready;
         pslverr              <= next_pslverr;
         flash_cmd            <= next_flash;
         blk_busy             <= next_blk_busy;
         overlay_active       <= next_overlay;
         ext_irq_one          <= next_irq;
         ext_irq_one_internal <= next_irq_int;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_cmd_write;
      wr_cmd && !busy;
   endsequence

   sequence s_timed_start;
      tstart ##1 flash_cmd.req;
   endsequence

   property p_iap_gate;
      (s_cmd_write and !iap_en) |=> !flash_cmd.req && !busy && $stable(cmd);
   endproperty
   a_iap_gate: assert property (p_iap_gate)
      else $error("command acted on with programming disabled");

   property p_busy_hold;
      (st == ST_RUN && !tdone) |=> busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("pending flag dropped before the operation ended");

   property p_timed_start;
      s_timed_start |-> busy && osc_en;
   endproperty
   a_timed_start: assert property (p_timed_start)
      else $error("timed operation started without pending flag or oscillator");

   property p_idle_after_done;
      (tdone && st == ST_RUN) |=> !busy && !rd_mux[fiap_pkg::STAT_BUSY_BIT];
   endproperty
   a_idle_after_done: assert property (p_idle_after_done)
      else $error("pending flag still set after completion");

   property p_osc_only_run;
      osc_en |-> st == ST_RUN;
   endproperty
   a_osc_only_run: assert property (p_osc_only_run)
      else $error("oscillator enabled without a timed operation");

   property p_osc_off;
      tdone |-> !osc_en;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator left on after completion");

   property p_signature;
      (accept && dec_sig && addr_lo == fiap_pkg::SIG_MFR_ADDR) |=> data == MFR_ID;
   endproperty
   a_signature: assert property (p_signature)
      else $error("signature byte not returned");

   property p_cross_block;
      (tstart && issue_src == fiap_pkg::SRC_PRIMARY) |=> flash_cmd.blk == 1'b1;
   endproperty
   a_cross_block: assert property (p_cross_block)
      else $error("primary code did not target the secondary block");

   property p_cross_back;
      (tstart && issue_src == fiap_pkg::SRC_SECONDARY) |=> flash_cmd.blk == 1'b0;
   endproperty
   a_cross_back: assert property (p_cross_back)
      else $error("secondary code did not target the primary block");

   property p_lock;
      (accept && dec_op != fiap_pkg::OP_READ && dec_op != fiap_pkg::OP_NONE &&
       lock_blk[dec_blk]) |=> !flash_cmd.req && refused;
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked block was programmed");

   property p_ignore_busy;
      (wr_cmd && busy) |=> $stable(cmd) && !flash_cmd.req;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("command write taken while pending");

   property p_irq;
      (tdone && cmd[fiap_pkg::CMD_IRQ_BIT]) |=> ext_irq_one ##1 !ext_irq_one;
   endproperty
   a_irq: assert property (p_irq)
      else $error("completion interrupt missing or too long");

   property p_apb_answer;
      (acc && !pready) |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("bus answer not given in one wait cycle");

endmodule // fiap_mailbox
`default_nettype wire

// [dv/fiap_flash_model.sv]
// far-side model: timing oscillator and a small flash byte store
`timescale 1ns/1ps
`default_nettype none
module fiap_flash_model (
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire logic                  osc_en,
   input  wire fiap_pkg::fiap_flash_t flash_cmd,
   output logic                       osc_tick,
   output logic [7:0]                 flash_rdata
);
   logic [7:0] mem [16];
   logic       rd_q;
   logic       rd_now;
   logic [7:0] idle;
   // ==========================================
   // erased store; outside a read the data lines toggle every cycle
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 8'hff;
   end
   assign rd_now      = flash_cmd.req && (flash_cmd.op == fiap_pkg::OP_READ);
   assign flash_rdata = (rd_now || rd_q) ? mem[flash_cmd.addr[3:0]] : idle;
   // ticks only while enabled, every other cycle
   always @(posedge core_clk) begin
      osc_tick <= nrst && osc_en && !osc_tick;
      rd_q     <= rd_now;
      idle     <= nrst ? ~flash_rdata : 8'h00;
      if (flash_cmd.req && (flash_cmd.op == fiap_pkg::OP_PROGRAM)) begin
         mem[flash_cmd.addr[3:0]] <= flash_cmd.wdata;
      end
   end
endmodule // fiap_flash_model
`default_nettype wire

// [dv/flash_iap_mailbox_control_tb.sv]
// testbench of the flash mailbox controller
`timescale 1ns/1ps
`default_nettype none
module flash_iap_mailbox_control_tb;
   logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, pin_n, osc_tick, osc_en;
   logic ovl, irq, irq_int;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] pc;
   logic [1:0]  lock, busy;
   logic [7:0]  frd;
   logic        e;
   fiap_pkg::fiap_src_t   src;
   fiap_pkg::fiap_flash_t fc, last;
   int fail_count = 0, total_checks = 0, reqs = 0, irqs = 0;
   typedef struct {logic [11:0] a; logic [7:0] d; logic [31:0] x; logic err;} fiap_row_t;
   fiap_row_t rows [5] = '{'{12'h014, 8'hbc, 32'h0, 1'b0}, '{12'h008, 8'h5a, 32'h5a, 1'b0},
      '{12'h00c, 8'hc3, 32'hc3, 1'b0}, '{12'h000, 8'hff, 32'h0, 1'b0},
      '{12'h018, 8'h77, 32'h0, 1'b1}};
   fiap_mailbox i_fiap_mailbox (.core_clk(core_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_access_pin_n(pin_n), .issue_src(src),
      .issue_pc(pc), .lock_blk(lock), .osc_tick(osc_tick), .flash_rdata(frd),
      .flash_cmd(fc), .osc_en(osc_en), .blk_busy(busy), .overlay_active(ovl),
      .ext_irq_one(irq), .ext_irq_one_internal(irq_int));
   fiap_flash_model i_fiap_flash_model (.core_clk(core_clk), .nrst(nrst), .osc_en(osc_en),
      .flash_cmd(fc), .osc_tick(osc_tick), .flash_rdata(frd));
   // ==========================================
   // clock, request and completion monitors
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (fc.req === 1'b1) begin
         reqs++;
         last = fc;
      end
      if (irq === 1'b1) irqs++;
   end
   // ==========================================
   // comparison, bus and closing tasks
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 8'h00);
      check(n, r, x);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 200; i++) begin
         apb(1'b0, 12'h000, 8'h00);
         if (r[2] === 1'b0) break;
      end
      check("idle", {31'h0, r[2]}, 32'h0);
   endtask
   task automatic cmd(input fiap_pkg::fiap_src_t s, input logic [15:0] p, input logic [7:0] c);
      src <= s;
      pc <= p;
      apb(1'b1, 12'h004, c);
      repeat (2) @(posedge core_clk);
   endtask
   task automatic stop_test();
      if (fail_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
   // ==========================================
   // main sequence
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, lock} = '0;
      pin_n = 1'b0; pc = 16'h4000; src = fiap_pkg::SRC_PRIMARY;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      rd("status", 12'h000, 32'h0);
      check("osc", {31'h0, osc_en}, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         rd("reg", rows[i].a, rows[i].x);
         check("err", {31'h0, e}, {31'h0, rows[i].err});
      end
      apb(1'b1, 12'h008, 8'h30);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0a);
      rd("cmd_off", 12'h004, 32'h0);
      apb(1'b1, 12'h014, 8'h40);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0a);
      rd("mfr", 12'h010, 32'h5a);
      apb(1'b1, 12'h008, 8'h31);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0a);
      rd("dev", 12'h010, 32'h3c);
      {lock, pin_n} <= 3'b000;
      apb(1'b1, 12'h008, 8'h00);
      apb(1'b1, 12'h00c, 8'h00);
      apb(1'b1, 12'h010, 8'ha5);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h8e);
      check("busy", {28'h0, busy, osc_en, irq_int}, 32'hb);
      check("blk", {31'h0, last.blk}, 32'h1);
      rd("pend", 12'h000, 32'h4);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0c);
      wait_idle();
      check("reqs", reqs, 1);
      check("irq", {irqs[30:0], osc_en}, 2);
      cmd(fiap_pkg::SRC_EXTERNAL, 16'hf000, 8'h0c); // verify code runs externally
      check("ext", {31'h0, last.blk}, 32'h0);
      apb(1'b1, 12'h00c, 8'he0);
      cmd(fiap_pkg::SRC_EXTERNAL, 16'hf000, 8'h0c);
      check("ext2", {31'h0, last.blk}, 32'h1);
      wait_idle();
      rd("vfy", 12'h010, 32'ha5);
      pin_n <= 1'b1;
      apb(1'b1, 12'h014, 8'h41);
      apb(1'b1, 12'h00c, 8'h00);
      cmd(fiap_pkg::SRC_SECONDARY, 16'h0100, 8'h0e);
      check("sec", {30'h0, ovl, last.blk}, 32'h2);
      wait_idle();
      check("reqs2", reqs, 4);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h0100, 8'h0e);
      rd("hidden", 12'h000, 32'h1);
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0a);
      rd("clear", 12'h000, 32'h0);
      lock <= 2'b10;
      cmd(fiap_pkg::SRC_PRIMARY, 16'h4000, 8'h0e);
      rd("locked", 12'h000, 32'h1);
      check("reqs3", reqs, 4);
      stop_test();
   end
endmodule // flash_iap_mailbox_control_tb
`default_nettype wire
